// ===== src/swcd_pkg.sv
// Purpose: Shared constants and types for the sweep command decoder
// Assumes: 8-bit instrument bus, 20 MHz system clock
// Notes: Register offsets are bus addresses, compared against the full address byte
package swcd_pkg;
	// ------------------------------------------------------------
	// Bus addresses
	// ------------------------------------------------------------
	localparam logic [7:0] SWCD_ADDR_SUBREG = 8'h0f;
	localparam logic [7:0] SWCD_ADDR_ACTION = 8'h1f;
	localparam logic [7:0] SWCD_ADDR_RDBACK = 8'h9f;
	localparam int SWCD_NUM_SUB = 4;
	localparam int SWCD_SYNC_STAGES = 2;
	// ------------------------------------------------------------
	// Action select register bits
	// ------------------------------------------------------------
	localparam int SWCD_ACT_ABORT = 0;
	localparam int SWCD_ACT_IGNORE = 1;
	localparam int SWCD_ACT_GATEOFF = 2;
	localparam int SWCD_ACT_START = 3;
	localparam int SWCD_ACT_SPARE_LO = 4;
	localparam int SWCD_ACT_SPARE_HI = 5;
	localparam int SWCD_ACT_SEL_LO = 6;
	localparam int SWCD_ACT_SEL_HI = 7;
	localparam logic [5:0] SWCD_ACT_RESET = 6'h00;
	// ------------------------------------------------------------
	// Sub-address 0 (mode) and 1 (rate) fields
	// ------------------------------------------------------------
	localparam int SWCD_M_SINGLE = 0;
	localparam int SWCD_M_EOSINT = 1;
	localparam int SWCD_M_TRIG_LO = 3;
	localparam int SWCD_M_TRIG_HI = 4;
	localparam int SWCD_M_HOLD_LO = 5;
	localparam int SWCD_M_HOLD_HI = 6;
	localparam int SWCD_R_CODE_HI = 4;
	localparam logic [7:0] SWCD_SUB_RESET = 8'h00;
	localparam logic [4:0] SWCD_RATE_20US = 5'h1b;
	localparam logic [4:0] SWCD_RATE_50US = 5'h17;
	localparam logic [4:0] SWCD_RATE_100US = 5'h13;
	localparam logic [4:0] SWCD_RATE_200US = 5'h0b;
	localparam logic [4:0] SWCD_RATE_500US = 5'h07;
	localparam logic [4:0] SWCD_RATE_1MS = 5'h03;
	localparam logic [7:0] SWCD_DOUT_RESET = 8'h00;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SWCD_TRIG_FREE = 2'h0,
		SWCD_TRIG_INT = 2'h1,
		SWCD_TRIG_EXT = 2'h2,
		SWCD_TRIG_LINE = 2'h3
	} swcd_trig_t;
	typedef enum logic [2:0] {
		SWCD_RS_20US,
		SWCD_RS_50US,
		SWCD_RS_100US,
		SWCD_RS_200US,
		SWCD_RS_500US,
		SWCD_RS_1MS,
		SWCD_RS_OTHER
	} swcd_rate_t;
endpackage

// ===== src/swcd_if.sv
// Purpose: Write carrier from the decoder to the sub-address registers
// Assumes: One write strobe per bus cycle
// Notes: en is one-hot, driven from the action select bits
`timescale 1ns/1ps
interface swcd_if;
	logic wr;
	logic [7:0] wdata;
	logic [3:0] en;
	modport src(output wr, output wdata, output en);
	modport sink(input wr, input wdata, input en);
endinterface

// ===== src/swcd_subreg.sv
// Purpose: One sub-address command register behind the shared write address
// Assumes: Write strobe already qualified by the bus end-of-cycle edge
// Notes: Instantiated once per sub-address
`timescale 1ns/1ps
module swcd_subreg
	import swcd_pkg::*;
#(
	parameter int IDX = 0
) (
	input wire logic clk,
	input wire logic rst_b,
	swcd_if.sink bus,
	output logic [7:0] q
);
	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	wire logic hit = bus.wr && bus.en[IDX];

	// Load only when this sub-address is the selected target
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= SWCD_SUB_RESET;
		end else if (hit) begin
			q <= bus.wdata; // RQ3 RQ16
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_sub_keep;
		@(posedge clk) disable iff (!rst_b)
		!hit |=> q == $past(q);
	endproperty
	a_sub_keep: assert property (p_sub_keep) else $error("sub reg changed without select"); // RQ16

	property p_sub_load;
		@(posedge clk) disable iff (!rst_b)
		hit |=> q == $past(bus.wdata);
	endproperty
	a_sub_load: assert property (p_sub_load) else $error("sub reg missed its write"); // RQ3
endmodule

// ===== src/swcd_decoder.sv
// Purpose: Instrument bus port decoder and sweep command registers
// Assumes: Bus pins are asynchronous to clk; DATA VALID pulses span several clocks
// Notes: Data is held while the strobe is high and committed on its falling edge
//
// Behaviour
// RQ1: Decode write addresses 0F and 1F and read address 9F.
// RQ2: Give each of the three addresses its own active-low select.
// RQ3: Address 0F holds four sub-address registers chosen by a 1F field.
// RQ4: Bits 6 and 7 of 1F decode to a one-of-four target enable.
// RQ5: Keep written 1F data in a six-bit register.
// RQ6: Start and abort are one-shot actions; other command bits persist.
// RQ7: Bit 3 of 1F starts one sweep when single-sweep mode is on.
// RQ8: Bit 0 of sub-address 0 selects single sweep, low is continuous.
// RQ9: Sub-address 1 bits 0 to 4 hold the sweep rate code.
// RQ10: Rate codes decode to 20, 50, 100, 200, 500 us and 1 ms.
// RQ11: Data is captured at the falling edge of data valid.
// RQ12: Bit 0 of 1F aborts the running sweep.
// RQ13: 1F bit 1 ignores triggers; bit 2 disables the sweep gate.
// RQ14: Sub-address 0 bits 3 and 4 choose the trigger source.
// RQ15: Drive the data bus only during a read of 9F with valid high.
// RQ16: A 0F write changes only the selected sub-address register.
`timescale 1ns/1ps
module swcd_decoder
	import swcd_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] bus_addr,
	input wire logic [7:0] bus_din,
	input wire logic bus_valid,
	output logic [7:0] bus_dout,
	output logic bus_doe_b,
	output logic sel_sub_b,
	output logic sel_act_b,
	output logic sel_rd_b,
	output logic single_sweep,
	output logic sweep_start,
	output logic sweep_abort,
	output logic trig_ignore,
	output logic gate_disable,
	output swcd_trig_t trig_src,
	output logic [1:0] holdoff_sel,
	output logic eos_int_en,
	output logic [4:0] rate_code,
	output swcd_rate_t rate_sel
);
	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [7:0] addr_s1_ff, addr_s2_ff, dat_s1_ff, dat_s2_ff;
	logic valid_s1_ff, valid_s2_ff, valid_s3_ff;
	logic [7:0] hold_addr_ff, hold_dat_ff;

	// Two flops on every pin before any decode reads it
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			addr_s1_ff <= 8'h00;
			addr_s2_ff <= 8'h00;
			dat_s1_ff <= 8'h00;
			dat_s2_ff <= 8'h00;
			valid_s1_ff <= 1'b0;
			valid_s2_ff <= 1'b0;
			valid_s3_ff <= 1'b0;
		end else begin
			addr_s1_ff <= bus_addr;
			addr_s2_ff <= addr_s1_ff;
			dat_s1_ff <= bus_din;
			dat_s2_ff <= dat_s1_ff;
			valid_s1_ff <= bus_valid;
			valid_s2_ff <= valid_s1_ff;
			valid_s3_ff <= valid_s2_ff;
		end
	end

	// Hold the last stable word while valid is high; the pins may move after the edge
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hold_addr_ff <= 8'h00;
			hold_dat_ff <= 8'h00;
		end else if (valid_s2_ff) begin
			hold_addr_ff <= addr_s2_ff;
			hold_dat_ff <= dat_s2_ff;
		end
	end

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	wire logic strobe_fall = valid_s3_ff && !valid_s2_ff; // RQ11
	wire logic hit_sub = valid_s2_ff && (addr_s2_ff == SWCD_ADDR_SUBREG); // RQ1
	wire logic hit_act = valid_s2_ff && (addr_s2_ff == SWCD_ADDR_ACTION); // RQ1
	wire logic hit_rd = valid_s2_ff && (addr_s2_ff == SWCD_ADDR_RDBACK); // RQ1
	wire logic wr_sub = strobe_fall && (hold_addr_ff == SWCD_ADDR_SUBREG); // RQ11
	wire logic wr_act = strobe_fall && (hold_addr_ff == SWCD_ADDR_ACTION); // RQ11

	// Selects follow the synchronised bus, active low
	assign sel_sub_b = !hit_sub; // RQ2
	assign sel_act_b = !hit_act; // RQ2
	assign sel_rd_b = !hit_rd; // RQ2

	// ------------------------------------------------------------
	// Action select register
	// ------------------------------------------------------------
	logic [5:0] act_ff;
	logic start_ff, abort_ff;
	wire logic [5:0] nxt_act = {hold_dat_ff[SWCD_ACT_SEL_HI:SWCD_ACT_SPARE_LO],
		hold_dat_ff[SWCD_ACT_GATEOFF:SWCD_ACT_IGNORE]};

	// Bits 0 and 3 are actions, not state, so only six bits are kept
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			act_ff <= SWCD_ACT_RESET;
		end else if (wr_act) begin
			act_ff <= nxt_act; // RQ5 RQ6
		end
	end

	// One-clock actions; start is refused unless single sweep is already selected
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			start_ff <= 1'b0;
			abort_ff <= 1'b0;
		end else begin
			start_ff <= wr_act && hold_dat_ff[SWCD_ACT_START] && single_sweep; // RQ7 RQ6
			abort_ff <= wr_act && hold_dat_ff[SWCD_ACT_ABORT]; // RQ12 RQ6
		end
	end

	wire logic [1:0] sub_sel = act_ff[5:4];
	assign sweep_start = start_ff;
	assign sweep_abort = abort_ff;
	assign trig_ignore = act_ff[0]; // RQ13
	assign gate_disable = act_ff[1]; // RQ13

	// ------------------------------------------------------------
	// Sub-address registers
	// ------------------------------------------------------------
	swcd_if sub_bus();
	logic [7:0] sub_q [SWCD_NUM_SUB];

	// One-of-four target from the stored select field
	assign sub_bus.wr = wr_sub;
	assign sub_bus.wdata = hold_dat_ff;
	assign sub_bus.en = 4'h1 << sub_sel; // RQ4

	for (genvar gi = 0; gi < SWCD_NUM_SUB; gi++) begin : g_sub
		swcd_subreg #(.IDX(gi)) u_sub (
			.clk(clk),
			.rst_b(rst_b),
			.bus(sub_bus.sink),
			.q(sub_q[gi])
		);
	end

	// Mode fields of sub-address 0, rate of sub-address 1
	assign single_sweep = sub_q[0][SWCD_M_SINGLE]; // RQ8
	assign eos_int_en = sub_q[0][SWCD_M_EOSINT];
	assign trig_src = swcd_trig_t'(sub_q[0][SWCD_M_TRIG_HI:SWCD_M_TRIG_LO]); // RQ14
	assign holdoff_sel = sub_q[0][SWCD_M_HOLD_HI:SWCD_M_HOLD_LO];
	assign rate_code = sub_q[1][SWCD_R_CODE_HI:0]; // RQ9

	// Rate decode; unlisted codes are reported, not guessed
	assign rate_sel = (rate_code == SWCD_RATE_20US) ? SWCD_RS_20US : // RQ10
		(rate_code == SWCD_RATE_50US) ? SWCD_RS_50US :
		(rate_code == SWCD_RATE_100US) ? SWCD_RS_100US :
		(rate_code == SWCD_RATE_200US) ? SWCD_RS_200US :
		(rate_code == SWCD_RATE_500US) ? SWCD_RS_500US :
		(rate_code == SWCD_RATE_1MS) ? SWCD_RS_1MS : SWCD_RS_OTHER;

	// ------------------------------------------------------------
	// Read-back port
	// ------------------------------------------------------------
	logic drive_ff;
	logic [7:0] dout_ff;
	wire logic [7:0] nxt_dout = {sub_sel, act_ff[1:0], sub_q[0][SWCD_M_TRIG_HI:SWCD_M_TRIG_LO],
		eos_int_en, single_sweep};

	// Drive only inside a read of the read address; released otherwise
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			drive_ff <= 1'b0;
			dout_ff <= SWCD_DOUT_RESET;
		end else begin
			drive_ff <= hit_rd; // RQ15
			dout_ff <= nxt_dout;
		end
	end

	assign bus_doe_b = !drive_ff;
	assign bus_dout = dout_ff;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_sel_sub;
		@(posedge clk) disable iff (!rst_b)
		!sel_sub_b |-> valid_s2_ff && addr_s2_ff == 8'h0f && sel_act_b && sel_rd_b;
	endproperty
	a_sel_sub: assert property (p_sel_sub) else $error("0F select without match"); // RQ2

	property p_sel_rd;
		@(posedge clk) disable iff (!rst_b)
		(valid_s2_ff && addr_s2_ff == 8'h9f) |-> !sel_rd_b;
	endproperty
	a_sel_rd: assert property (p_sel_rd) else $error("9F select missing"); // RQ1

	property p_start;
		@(posedge clk) disable iff (!rst_b)
		(wr_act && hold_dat_ff[3] && single_sweep) |=> sweep_start ##1 !sweep_start;
	endproperty
	a_start: assert property (p_start) else $error("start pulse wrong"); // RQ7

	property p_no_start;
		@(posedge clk) disable iff (!rst_b)
		!single_sweep |=> !sweep_start;
	endproperty
	a_no_start: assert property (p_no_start) else $error("start in continuous mode"); // RQ7

	property p_abort;
		@(posedge clk) disable iff (!rst_b)
		sweep_abort |-> $past(wr_act) && $past(hold_dat_ff[0]) ##1 !sweep_abort;
	endproperty
	a_abort: assert property (p_abort) else $error("abort pulse wrong"); // RQ12

	property p_act_store;
		@(posedge clk) disable iff (!rst_b)
		wr_act |=> trig_ignore == $past(hold_dat_ff[1]) && gate_disable == $past(hold_dat_ff[2])
			&& sub_sel == $past(hold_dat_ff[7:6]);
	endproperty
	a_act_store: assert property (p_act_store) else $error("1F bits not stored"); // RQ5

	property p_act_hold;
		@(posedge clk) disable iff (!rst_b)
		!wr_act |=> $stable(act_ff);
	endproperty
	a_act_hold: assert property (p_act_hold) else $error("1F bits lost"); // RQ6

	property p_target;
		@(posedge clk) disable iff (!rst_b)
		wr_sub && sub_sel == 2'h1 |=> rate_code == $past(hold_dat_ff[4:0]) && $stable(single_sweep);
	endproperty
	a_target: assert property (p_target) else $error("wrong sub register loaded"); // RQ3

	property p_drive;
		@(posedge clk) disable iff (!rst_b)
		!bus_doe_b |-> $past(valid_s2_ff) && $past(addr_s2_ff) == 8'h9f;
	endproperty
	a_drive: assert property (p_drive) else $error("bus driven outside read"); // RQ15

	property p_rate;
		@(posedge clk) disable iff (!rst_b)
		rate_code == 5'h1b |-> rate_sel == SWCD_RS_20US;
	endproperty
	a_rate: assert property (p_rate) else $error("rate decode wrong"); // RQ10

	c_single: cover property (@(posedge clk) disable iff (!rst_b) sweep_start);
	c_abort: cover property (@(posedge clk) disable iff (!rst_b) sweep_abort);
	c_read: cover property (@(posedge clk) disable iff (!rst_b) !bus_doe_b);
	c_rate1ms: cover property (@(posedge clk) disable iff (!rst_b) rate_sel == SWCD_RS_1MS);
endmodule

// ===== test/swcd_host.sv
// Purpose: Microcomputer model driving the instrument bus of the sweep decoder
// Assumes: Pins move on the falling clock edge, valid is held five clocks
// Notes: Released address and data lines show the inverse of the last value
`timescale 1ns/1ps
module swcd_host (
	input wire logic clk,
	output logic [7:0] bus_addr,
	output logic [7:0] bus_din,
	output logic bus_valid,
	input wire logic [7:0] bus_dout,
	input wire logic bus_doe_b
);
	// ------------------------------------------------------------
	// Idle bus
	// ------------------------------------------------------------
	initial begin
		bus_addr = 8'h00;
		bus_din = 8'h00;
		bus_valid = 1'b0;
	end
	// Raise valid with address and data, then keep them still
	task automatic open_cyc(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		bus_addr = a;
		bus_din = d;
		bus_valid = 1'b1;
		repeat (4) @(negedge clk);
	endtask
	// Take the read data, drop valid, then leave a quiet gap
	// Lines are scrambled after release so a late capture cannot pass
	// Read data is taken at the falling edge, away from the edge that reloads it
	task automatic close_cyc(output logic [7:0] rd);
		@(negedge clk);
		rd = bus_dout;
		bus_valid = 1'b0;
		@(negedge clk);
		bus_addr = ~bus_addr;
		bus_din = ~bus_din;
		repeat (6) @(negedge clk);
	endtask
endmodule

// ===== test/tb.sv
// Purpose: Self-checking bench for the sweep command decoder
// Assumes: 20 MHz clock, host model owns the bus pins
// Notes: Expected values follow the register rules, not the design outputs
`timescale 1ns/1ps
module tb;
	import swcd_pkg::*;
	logic clk;
	logic rst_b;
	logic [7:0] bus_addr;
	logic [7:0] bus_din;
	logic bus_valid;
	logic [7:0] bus_dout;
	logic bus_doe_b;
	logic sel_sub_b;
	logic sel_act_b;
	logic sel_rd_b;
	logic single_sweep;
	logic sweep_start;
	logic sweep_abort;
	logic trig_ignore;
	logic gate_disable;
	swcd_trig_t trig_src;
	logic [1:0] holdoff_sel;
	logic eos_int_en;
	logic [4:0] rate_code;
	swcd_rate_t rate_sel;
	int mismatches;
	int compares;
	int starts;
	int aborts;
	swcd_decoder swcd_decoder_inst (.clk(clk), .rst_b(rst_b), .bus_addr(bus_addr),
		.bus_din(bus_din), .bus_valid(bus_valid), .bus_dout(bus_dout), .bus_doe_b(bus_doe_b),
		.sel_sub_b(sel_sub_b), .sel_act_b(sel_act_b), .sel_rd_b(sel_rd_b),
		.single_sweep(single_sweep), .sweep_start(sweep_start), .sweep_abort(sweep_abort),
		.trig_ignore(trig_ignore), .gate_disable(gate_disable), .trig_src(trig_src),
		.holdoff_sel(holdoff_sel), .eos_int_en(eos_int_en), .rate_code(rate_code),
		.rate_sel(rate_sel));
	swcd_host swcd_host_inst (.clk(clk), .bus_addr(bus_addr), .bus_din(bus_din),
		.bus_valid(bus_valid), .bus_dout(bus_dout), .bus_doe_b(bus_doe_b));
	// ------------------------------------------------------------
	// Clock, pulse counters and checking
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Count one-shot pulses; a stuck pulse would be counted many times
	always @(posedge clk) begin
		if (sweep_start === 1'b1) starts++;
		if (sweep_abort === 1'b1) aborts++;
	end
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("mismatches=%0d compares=%0d", mismatches, compares);
		if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// One bus cycle; selects and output enable are judged mid-cycle
	task automatic cyc(input logic [7:0] a, input logic [7:0] d, output logic [7:0] rd);
		swcd_host_inst.open_cyc(a, d);
		chk("sel_sub_b", 8'(sel_sub_b), 8'(a != SWCD_ADDR_SUBREG));
		chk("sel_act_b", 8'(sel_act_b), 8'(a != SWCD_ADDR_ACTION));
		chk("sel_rd_b", 8'(sel_rd_b), 8'(a != SWCD_ADDR_RDBACK));
		chk("bus_doe_b", 8'(bus_doe_b), 8'(a != SWCD_ADDR_RDBACK));
		swcd_host_inst.close_cyc(rd);
		chk("bus_doe_b idle", 8'(bus_doe_b), 8'h01);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] rd;
		cyc(a, d, rd);
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		chk("sel_sub_b", 8'(sel_sub_b), 8'h01);
		chk("bus_doe_b", 8'(bus_doe_b), 8'h01);
		chk("single_sweep", 8'(single_sweep), 8'h00);
		chk("rate_sel", 8'(rate_sel), 8'(SWCD_RS_OTHER));
	endtask
	// Every rate code through sub-address 1
	task automatic t_rates();
		logic [4:0] codes [6] = '{5'h1b, 5'h17, 5'h13, 5'h0b, 5'h07, 5'h03};
		wr(SWCD_ADDR_ACTION, 8'h40);
		for (int i = 0; i < 6; i++) begin
			wr(SWCD_ADDR_SUBREG, {3'h0, codes[i]});
			chk("rate_code", 8'(rate_code), 8'(codes[i]));
			chk("rate_sel", 8'(rate_sel), 8'(i));
			chk("single_sweep", 8'(single_sweep), 8'h00);
		end
	endtask
	// Trigger sources and single sweep through sub-address 0
	task automatic t_mode();
		wr(SWCD_ADDR_ACTION, 8'h00);
		for (int t = 0; t < 4; t++) begin
			wr(SWCD_ADDR_SUBREG, {3'h0, t[1:0], 3'h1});
			chk("trig_src", 8'(trig_src), 8'(t));
			chk("single_sweep", 8'(single_sweep), 8'h01);
			chk("rate_code", 8'(rate_code), 8'h03);
		end
		// Long holdoff and end-of-sweep interrupt, trigger source kept at line
		wr(SWCD_ADDR_SUBREG, 8'h5b);
		chk("holdoff_sel", 8'(holdoff_sel), 8'h02);
		chk("eos_int_en", 8'(eos_int_en), 8'h01);
		chk("trig_src", 8'(trig_src), 8'h03);
		wr(SWCD_ADDR_ACTION, 8'h80);
		wr(SWCD_ADDR_SUBREG, 8'h00);
		wr(SWCD_ADDR_ACTION, 8'hc0);
		wr(SWCD_ADDR_SUBREG, 8'h00);
		chk("trig_src", 8'(trig_src), 8'h03);
		chk("rate_code", 8'(rate_code), 8'h03);
		wr(SWCD_ADDR_RDBACK, 8'h00);
		chk("single_sweep", 8'(single_sweep), 8'h01);
	endtask
	// Start, abort and the stored action bits
	task automatic t_action();
		int s0;
		int a0;
		s0 = starts;
		a0 = aborts;
		wr(SWCD_ADDR_ACTION, 8'h0e);
		chk("start pulses", 8'(starts - s0), 8'h01);
		chk("trig_ignore", 8'(trig_ignore), 8'h01);
		chk("gate_disable", 8'(gate_disable), 8'h01);
		wr(SWCD_ADDR_ACTION, 8'h01);
		chk("abort pulses", 8'(aborts - a0), 8'h01);
		chk("start pulses", 8'(starts - s0), 8'h01);
		chk("trig_ignore", 8'(trig_ignore), 8'h00);
		wr(SWCD_ADDR_SUBREG, 8'h00);
		wr(SWCD_ADDR_ACTION, 8'h08);
		chk("start pulses", 8'(starts - s0), 8'h01);
	endtask
	// Read-back drives the bus only on the read address
	task automatic t_read();
		logic [7:0] rd;
		wr(SWCD_ADDR_ACTION, 8'h46);
		cyc(SWCD_ADDR_RDBACK, 8'h00, rd);
		chk("bus_dout", rd, 8'h70);
	endtask
	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		mismatches = 0;
		compares = 0;
		starts = 0;
		aborts = 0;
		rst_b = 1'b0;
		repeat (20) @(negedge clk);
		rst_b = 1'b1;
		t_reset();
		t_rates();
		t_mode();
		t_action();
		t_read();
		final_report();
	end
	// Whole run needs about 24 bus cycles of 13 clocks; a hang stops well beyond that
	initial begin
		#1ms;
		mismatches++;
		final_report();
	end
endmodule
